// *** core/sewa_fifo2.sv ***
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: single clock
// Notes: outputs come straight from registers
`default_nettype none

module sewa_fifo2 #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  logic tail_valid_reg;
  logic [W-1:0] tail_reg;
  logic push;
  logic pop;

  assign in_ready = ~tail_valid_reg;
  assign push = in_valid & ~tail_valid_reg;
  assign pop = out_valid & out_ready;

  // ==========================================================================
  // head and tail slots
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      out_valid <= 1'b0;
      tail_valid_reg <= 1'b0;
      out_data <= '0;
      tail_reg <= '0;
    end
    else if (pop)
    begin
      if (tail_valid_reg)
      begin
        out_data <= tail_reg;
        tail_valid_reg <= 1'b0;
      end
      else
      begin
        out_valid <= push;
        if (push)
        begin
          out_data <= in_data;
        end
      end
    end
    else if (push)
    begin
      if (!out_valid)
      begin
        out_data <= in_data;
        out_valid <= 1'b1;
      end
      else
      begin
        tail_reg <= in_data;
        tail_valid_reg <= 1'b1;
      end
    end
  end

endmodule : sewa_fifo2

`default_nettype wire

// *** core/sewa_pkg.sv ***
// Purpose: shared constants and types of the two-wire eeprom write-access target
// Assumes: system clock of 250 MHz
// Notes: all offsets, field positions and timing figures live here
`default_nettype none

package sewa_pkg;

  // ==========================================================================
  // device address word layout
  localparam logic [3:0] DEV_PREFIX = 4'ha;
  localparam int DEV_PREFIX_HI = 7;
  localparam int DEV_PREFIX_LO = 4;
  localparam int DEV_CS_HI_BIT = 3;
  localparam int DEV_CS_LO_BIT = 2;
  localparam int DEV_PAGE1_BIT = 2;
  localparam int DEV_PAGE0_BIT = 1;
  localparam int DEV_RW_BIT = 0;

  // ==========================================================================
  // widths and memory geometry
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 10;
  localparam int PAGE_OFS_W = 4;
  localparam int PAGE_ROW_W = 6;
  localparam int PAGE_BYTES = 16;
  localparam int PAGE_BITS_W = 2;
  localparam int DRAIN_W = 5;
  localparam int BIT_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] BIT_ACK_SLOT = 4'h8;
  localparam logic [BIT_CNT_W-1:0] BIT_ACK_END = 4'h9;

  // ==========================================================================
  // synchroniser lanes
  localparam int SYNC_W = 4;
  localparam int SYNC_SCL = 0;
  localparam int SYNC_SDA = 1;
  localparam int SYNC_CS_HI = 2;
  localparam int SYNC_CS_LO = 3;
  localparam logic [SYNC_W-1:0] SYNC_RST = 4'h3;

  // ==========================================================================
  // timing
  localparam int CLK_FREQ_MHZ = 250;
  localparam int PROG_TIME_US = 5000;
  // longest time in clk cycles; the integer product is exact, with no rounding
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_FREQ_MHZ;
  localparam int PROG_CNT_W = 21;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_ADDR,
    ST_DATA,
    ST_READ,
    ST_PROG
  } sewa_state_e;

endpackage : sewa_pkg

`default_nettype wire

// *** core/sewa_sync.sv ***
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to clk
// Notes: first stage is read only by the second stage
`default_nettype none

module sewa_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // ==========================================================================
  // per-bit double flop
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++)
    begin : g_bit
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          meta_reg[gi] <= RST_VAL[gi];
          q[gi] <= RST_VAL[gi];
        end
        else
        begin
          meta_reg[gi] <= d[gi];
          q[gi] <= meta_reg[gi];
        end
      end
    end
  endgenerate

endmodule : sewa_sync

`default_nettype wire

// *** core/sewa_top.sv ***
// Purpose: target side of a two-wire serial eeprom, write access and programming
// Assumes: scl, sda and chip-select pins are asynchronous to clk; scl far slower
// Notes: written page is drained through a two-entry buffer during programming
`default_nettype none

// Summary of operation
// - a data change while scl is high is a start or stop, not a bit
// - sda falling with scl high is a start; controller starts every command
// - sda rising with scl high is a stop
// - a stop ending a read sequence puts the device into standby
// - words are eight bits; device pulls sda low on the ninth clock
// - standby at power-up and after a stop once internal work ends
// - start, nine clocks, start then stop leaves the device ready
// - programming from the write stop lasts at most 5 ms; the code also holds it until every written byte has entered the two-entry buffer
// - device address word must begin with 1010 to be answered
// - 4K part matches bits 3 and 2 to pins; bit 1 is page bit
// - 8K part matches bit 3 to one pin; bits 2 and 1 are page bits
// - address bit 0 high means read, low means write
// - match is acknowledged; mismatch gets no ack and returns to standby
// - byte write is device address, word address, one data byte, then stop
// - after a write stop, program and ignore the bus until done
// - page write takes up to sixteen bytes, each acknowledged, ended by stop
// - only the low four word address bits advance after each byte
// - over sixteen bytes wrap inside the page and overwrite earlier ones
// - polling gets an acknowledge only after programming has finished
// - sample incoming bits on scl rise, change sda on scl fall
// - pages of sixteen bytes; 9-bit address in 4K, 10-bit in 8K
module sewa_top #(
  parameter int PROG_CYCLES = sewa_pkg::PROG_CYCLES,
  parameter bit IS_8K = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic chip_select_hi,
  input wire logic chip_select_lo,
  output logic standby,
  output logic prog_busy,
  output logic prog_valid,
  input wire logic prog_ready,
  output logic [sewa_pkg::ADDR_W-1:0] prog_addr,
  output logic [sewa_pkg::BYTE_W-1:0] prog_data
);

  localparam logic [sewa_pkg::PROG_CNT_W-1:0] PROG_LAST =
    sewa_pkg::PROG_CNT_W'(PROG_CYCLES - 1);
  localparam logic [sewa_pkg::DRAIN_W-1:0] DRAIN_END =
    sewa_pkg::DRAIN_W'(sewa_pkg::PAGE_BYTES);

  logic [sewa_pkg::SYNC_W-1:0] sync_q;
  logic scl_s;
  logic sda_s;
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  sewa_pkg::sewa_state_e state_reg;
  logic [sewa_pkg::BIT_CNT_W-1:0] bit_cnt_reg;
  logic [sewa_pkg::BYTE_W-1:0] shift_reg;
  logic rx_state;
  logic byte_done;
  logic ack_end;
  logic dev_match;
  logic ack_now;
  logic rw_reg;
  logic [sewa_pkg::PAGE_BITS_W-1:0] page_reg;
  logic [sewa_pkg::PAGE_ROW_W-1:0] row_reg;
  logic [sewa_pkg::PAGE_OFS_W-1:0] wr_ofs_reg;
  logic [sewa_pkg::BYTE_W-1:0] page_buf [sewa_pkg::PAGE_BYTES];
  logic [sewa_pkg::PAGE_BYTES-1:0] mask_reg;
  logic [sewa_pkg::DRAIN_W-1:0] drain_idx_reg;
  logic [sewa_pkg::PAGE_OFS_W-1:0] drain_ofs;
  logic drain_done;
  logic [sewa_pkg::PROG_CNT_W-1:0] prog_cnt_reg;
  logic prog_done;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic sda_out_reg;

  // ==========================================================================
  // pin synchronisers and edge detection
  sewa_sync #(
    .W(sewa_pkg::SYNC_W),
    .RST_VAL(sewa_pkg::SYNC_RST)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .d({chip_select_lo, chip_select_hi, sda_in, scl_in}),
    .q(sync_q)
  );

  assign scl_s = sync_q[sewa_pkg::SYNC_SCL];
  assign sda_s = sync_q[sewa_pkg::SYNC_SDA];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_ev = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_ev = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  assign rx_state = (state_reg == sewa_pkg::ST_DEV) || (state_reg == sewa_pkg::ST_ADDR) ||
    (state_reg == sewa_pkg::ST_DATA);
  assign byte_done = scl_fall && rx_state && (bit_cnt_reg == sewa_pkg::BIT_ACK_SLOT);
  assign ack_end = scl_fall && (bit_cnt_reg == sewa_pkg::BIT_ACK_END);

  assign dev_match =
    (shift_reg[sewa_pkg::DEV_PREFIX_HI:sewa_pkg::DEV_PREFIX_LO] == sewa_pkg::DEV_PREFIX) &&
    (shift_reg[sewa_pkg::DEV_CS_HI_BIT] == sync_q[sewa_pkg::SYNC_CS_HI]) &&
    (IS_8K || (shift_reg[sewa_pkg::DEV_CS_LO_BIT] == sync_q[sewa_pkg::SYNC_CS_LO]));
  assign ack_now = ((state_reg == sewa_pkg::ST_DEV) && dev_match) ||
    (state_reg == sewa_pkg::ST_ADDR) || (state_reg == sewa_pkg::ST_DATA);

  // ==========================================================================
  // bit counter and shifter
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bit_cnt_reg <= '0;
    end
    else if (start_ev && state_reg != sewa_pkg::ST_PROG)
    begin
      bit_cnt_reg <= '0;
    end
    else if (scl_rise && rx_state && bit_cnt_reg < sewa_pkg::BIT_ACK_SLOT)
    begin
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
    end
    else if (byte_done)
    begin
      bit_cnt_reg <= ack_now ? sewa_pkg::BIT_ACK_END : '0;
    end
    else if (ack_end)
    begin
      bit_cnt_reg <= '0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      shift_reg <= '0;
    end
    else if (scl_rise && rx_state && bit_cnt_reg < sewa_pkg::BIT_ACK_SLOT)
    begin
      shift_reg <= {shift_reg[sewa_pkg::BYTE_W-2:0], sda_s};
    end
  end

  // ==========================================================================
  // transfer state
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= sewa_pkg::ST_IDLE;
    end
    else if (state_reg == sewa_pkg::ST_PROG)
    begin
      if (prog_done)
      begin
        state_reg <= sewa_pkg::ST_IDLE;
      end
    end
    else if (start_ev)
    begin
      state_reg <= sewa_pkg::ST_DEV;
    end
    else if (stop_ev)
    begin
      state_reg <= (state_reg == sewa_pkg::ST_DATA && mask_reg != '0) ?
        sewa_pkg::ST_PROG : sewa_pkg::ST_IDLE;
    end
    else if (byte_done && state_reg == sewa_pkg::ST_DEV && !dev_match)
    begin
      state_reg <= sewa_pkg::ST_IDLE;
    end
    else if (ack_end)
    begin
      unique case (state_reg)
        sewa_pkg::ST_DEV: state_reg <= rw_reg ? sewa_pkg::ST_READ : sewa_pkg::ST_ADDR;
        sewa_pkg::ST_ADDR: state_reg <= sewa_pkg::ST_DATA;
        sewa_pkg::ST_DATA: state_reg <= sewa_pkg::ST_DATA;
        sewa_pkg::ST_IDLE: state_reg <= sewa_pkg::ST_IDLE;
        sewa_pkg::ST_READ: state_reg <= sewa_pkg::ST_READ;
        sewa_pkg::ST_PROG: state_reg <= sewa_pkg::ST_PROG;
      endcase
    end
  end

  // ==========================================================================
  // address capture
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rw_reg <= 1'b0;
      page_reg <= '0;
      row_reg <= '0;
      wr_ofs_reg <= '0;
    end
    else if (byte_done && state_reg == sewa_pkg::ST_DEV && dev_match)
    begin
      rw_reg <= shift_reg[sewa_pkg::DEV_RW_BIT];
      page_reg <= IS_8K ?
        {shift_reg[sewa_pkg::DEV_PAGE1_BIT], shift_reg[sewa_pkg::DEV_PAGE0_BIT]} :
        {1'b0, shift_reg[sewa_pkg::DEV_PAGE0_BIT]};
    end
    else if (byte_done && state_reg == sewa_pkg::ST_ADDR)
    begin
      row_reg <= {page_reg, shift_reg[sewa_pkg::BYTE_W-1:sewa_pkg::PAGE_OFS_W]};
      wr_ofs_reg <= shift_reg[sewa_pkg::PAGE_OFS_W-1:0];
    end
    else if (byte_done && state_reg == sewa_pkg::ST_DATA)
    begin
      wr_ofs_reg <= wr_ofs_reg + 1'b1;
    end
  end

  // ==========================================================================
  // page buffer
  // up to sixteen page bytes
  always_ff @(posedge clk)
  begin
    if (byte_done && state_reg == sewa_pkg::ST_DATA)
    begin
      page_buf[wr_ofs_reg] <= shift_reg;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mask_reg <= '0;
    end
    else if (prog_done || (byte_done && state_reg == sewa_pkg::ST_ADDR))
    begin
      mask_reg <= '0;
    end
    else if (byte_done && state_reg == sewa_pkg::ST_DATA)
    begin
      mask_reg[wr_ofs_reg] <= 1'b1;
    end
  end

  // ==========================================================================
  // programming cycle and drain
  assign drain_ofs = drain_idx_reg[sewa_pkg::PAGE_OFS_W-1:0];
  assign drain_done = (drain_idx_reg == DRAIN_END);
  assign fifo_in_valid = (state_reg == sewa_pkg::ST_PROG) && !drain_done && mask_reg[drain_ofs];
  assign prog_done = (state_reg == sewa_pkg::ST_PROG) && drain_done &&
    (prog_cnt_reg == PROG_LAST);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      drain_idx_reg <= '0;
    end
    else if (state_reg != sewa_pkg::ST_PROG)
    begin
      drain_idx_reg <= '0;
    end
    else if (!drain_done && (!mask_reg[drain_ofs] || fifo_in_ready))
    begin
      drain_idx_reg <= drain_idx_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prog_cnt_reg <= '0;
    end
    else if (state_reg != sewa_pkg::ST_PROG)
    begin
      prog_cnt_reg <= '0;
    end
    else if (prog_cnt_reg != PROG_LAST)
    begin
      prog_cnt_reg <= prog_cnt_reg + 1'b1;
    end
  end

  sewa_fifo2 #(
    .W(sewa_pkg::ADDR_W + sewa_pkg::BYTE_W)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data({row_reg, drain_ofs, page_buf[drain_ofs]}),
    .out_valid(prog_valid),
    .out_ready(prog_ready),
    .out_data({prog_addr, prog_data})
  );

  // ==========================================================================
  // sda drive and status
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sda_oe_n <= 1'b1;
      sda_out_reg <= 1'b0;
      standby <= 1'b1;
      prog_busy <= 1'b0;
    end
    else
    begin
      // pull low only in ack slot
      if (byte_done && ack_now)
      begin
        sda_oe_n <= 1'b0;
      end
      else if (ack_end || start_ev || stop_ev || state_reg == sewa_pkg::ST_PROG)
      begin
        sda_oe_n <= 1'b1;
      end
      sda_out_reg <= 1'b0;
      // standby after stop and work done
      standby <= (state_reg == sewa_pkg::ST_IDLE);
      prog_busy <= (state_reg == sewa_pkg::ST_PROG);
    end
  end

  assign sda_out = sda_out_reg;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_byte_end;
    scl_fall && rx_state && bit_cnt_reg == sewa_pkg::BIT_ACK_SLOT;
  endsequence

  property p_start;
    start_ev && state_reg != sewa_pkg::ST_PROG |=> state_reg == sewa_pkg::ST_DEV
      && bit_cnt_reg == '0;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");

  property p_stop;
    stop_ev && state_reg inside {sewa_pkg::ST_DEV, sewa_pkg::ST_ADDR} |=>
      state_reg == sewa_pkg::ST_IDLE;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not taken");

  property p_read_standby;
    stop_ev && state_reg == sewa_pkg::ST_READ |=> ##1 standby;
  endproperty
  a_read_standby: assert property (p_read_standby) else $error("no standby");

  property p_ack_slot;
    s_byte_end ##0 ack_now |=> !sda_oe_n throughout (bit_cnt_reg == sewa_pkg::BIT_ACK_END)[*2];
  endproperty
  a_ack_slot: assert property (p_ack_slot) else $error("ack not driven");

  property p_mismatch;
    s_byte_end ##0 (state_reg == sewa_pkg::ST_DEV && !dev_match) |=>
      sda_oe_n && state_reg == sewa_pkg::ST_IDLE;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch acked");

  property p_prefix;
    s_byte_end ##0 (state_reg == sewa_pkg::ST_DEV &&
      shift_reg[sewa_pkg::DEV_PREFIX_HI:sewa_pkg::DEV_PREFIX_LO] != sewa_pkg::DEV_PREFIX)
      |=> sda_oe_n;
  endproperty
  a_prefix: assert property (p_prefix) else $error("bad prefix acked");

  property p_prog_quiet;
    state_reg == sewa_pkg::ST_PROG |=> sda_oe_n;
  endproperty
  a_prog_quiet: assert property (p_prog_quiet) else $error("sda driven in program");

  property p_wrap;
    s_byte_end ##0 state_reg == sewa_pkg::ST_DATA |=>
      wr_ofs_reg == $past(wr_ofs_reg) + 4'h1 && $stable(row_reg);
  endproperty
  a_wrap: assert property (p_wrap) else $error("page offset wrong");

  property p_release;
    !sda_oe_n |-> bit_cnt_reg == sewa_pkg::BIT_ACK_END;
  endproperty
  a_release: assert property (p_release) else $error("sda held outside ack");

  property p_prog_end;
    prog_done |=> state_reg == sewa_pkg::ST_IDLE ##1 standby && !prog_busy;
  endproperty
  a_prog_end: assert property (p_prog_end) else $error("program end wrong");

endmodule : sewa_top

`default_nettype wire

// *** tb/sewa_ctl_model.sv ***
// Purpose: bus controller model that drives scl and sda of the target
// Assumes: one bus bit lasts 16 clk, a 64 ns link clock
// Notes: ones release sda to the pull-up; scl stands high between frames
`default_nettype none

module sewa_ctl_model (
  input wire logic clk,
  input wire logic sda_wire,
  output var logic scl,
  output var logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic s;

  // ==========
  // idle bus
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt

  task automatic start_cond();
    sda = 1'b1;
    wt(4);
    scl = 1'b1;
    wt(4);
    sda = 1'b0;
    wt(4);
    scl = 1'b0;
    wt(4);
  endtask : start_cond

  task automatic stop_cond();
    sda = 1'b0;
    wt(4);
    scl = 1'b1;
    wt(4);
    sda = 1'b1;
    wt(4);
  endtask : stop_cond

  task automatic bit_cyc(input logic b, output logic seen);
    sda = b;
    wt(4);
    scl = 1'b1;
    wt(4);
    seen = sda_wire;
    wt(4);
    scl = 1'b0;
    wt(4);
  endtask : bit_cyc

  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_cyc(b[i], s);
    bit_cyc(1'b1, s);
    ack = ~s;
  endtask : put_byte

  task automatic recover();
    start_cond();
    repeat (9) bit_cyc(1'b1, s);
    start_cond();
    stop_cond();
  endtask : recover
endmodule : sewa_ctl_model

`default_nettype wire

// *** tb/tb.sv ***
// Purpose: self-checking bench of the two-wire eeprom write target
// Assumes: programming count shortened to PROG_N clk, 4K variant
// Notes: bus driven by sewa_ctl_model, program sink driven here
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PROG_N = 400;
  logic clk;
  logic rst;
  logic chip_select_hi;
  logic chip_select_lo;
  logic prog_ready;
  logic scl;
  logic ctl_sda;
  logic sda_wire;
  logic sda_out;
  logic sda_oe_n;
  logic standby;
  logic prog_busy;
  logic prog_valid;
  logic [sewa_pkg::ADDR_W-1:0] prog_addr;
  logic [sewa_pkg::BYTE_W-1:0] prog_data;
  logic [17:0] got_q[$];
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;

  // wired-and with pull-up
  assign sda_wire = ctl_sda & (sda_oe_n | sda_out);

  sewa_ctl_model ctl_u (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda(ctl_sda));

  sewa_top #(.PROG_CYCLES(PROG_N)) dut_u (
    .clk(clk),
    .rst(rst),
    .scl_in(scl),
    .sda_in(sda_wire),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .chip_select_hi(chip_select_hi),
    .chip_select_lo(chip_select_lo),
    .standby(standby),
    .prog_busy(prog_busy),
    .prog_valid(prog_valid),
    .prog_ready(prog_ready),
    .prog_addr(prog_addr),
    .prog_data(prog_data)
  );

  // ==========
  // clock, timeout and sink monitor
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (prog_valid === 1'b1 && prog_ready === 1'b1)
      got_q.push_back({prog_addr, prog_data});
    if (cyc == 20000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  // ==========
  // compares
  task automatic chk_flag(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s exp %b got %b", what, exp, got);
    end
  endtask : chk_flag

  task automatic chk_word(input string what, input logic [17:0] exp, input logic [17:0] got);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask : chk_word

  task automatic send(input logic [7:0] b, input logic exp_ack);
    logic a;
    ctl_u.put_byte(b, a);
    chk_flag("ack", exp_ack, a);
  endtask : send

  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (prog_busy !== lvl && n < lim)
    begin
      ctl_u.wt(1);
      n++;
    end
    chk_flag("prog_busy", lvl, prog_busy);
  endtask : wait_busy

  // ==========
  // scenarios
  task automatic test_reset();
    repeat (3) @(posedge clk);
    #1;
    chk_flag("standby", 1'b1, standby);
    chk_flag("prog_busy", 1'b0, prog_busy);
    chk_flag("sda_oe_n", 1'b1, sda_oe_n);
    chk_flag("sda_out", 1'b0, sda_out);
    chk_flag("prog_valid", 1'b0, prog_valid);
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    ctl_u.wt(6);
    chk_flag("standby", 1'b1, standby);
    $display("test reset done");
  endtask : test_reset

  task automatic test_strap();
    logic [1:0] q;
    for (int p = 0; p < 4; p++)
    begin
      chip_select_hi = p[1];
      chip_select_lo = p[0];
      q = 2'(p) ^ ((p % 2 == 0) ? 2'h1 : 2'h2);
      ctl_u.wt(4);
      ctl_u.start_cond();
      send({4'ha, p[1], p[0], 2'h0}, 1'b1);
      ctl_u.stop_cond();
      chk_flag("prog_busy", 1'b0, prog_busy);
      ctl_u.start_cond();
      send({4'ha, q, 2'h0}, 1'b0);
      ctl_u.stop_cond();
      chk_flag("standby", 1'b1, standby);
    end
    ctl_u.start_cond();
    send(8'hbc, 1'b0);
    ctl_u.stop_cond();
    chk_flag("sda_oe_n", 1'b1, sda_oe_n);
    $display("test strap done");
  endtask : test_strap

  task automatic test_byte();
    int t0;
    chip_select_hi = 1'b1;
    chip_select_lo = 1'b0;
    got_q.delete();
    ctl_u.wt(4);
    ctl_u.start_cond();
    send(8'haa, 1'b1);
    send(8'h37, 1'b1);
    send(8'h5c, 1'b1);
    ctl_u.stop_cond();
    t0 = cyc;
    wait_busy(1'b1, 20);
    chk_flag("standby", 1'b0, standby);
    ctl_u.start_cond();
    send(8'haa, 1'b0);
    ctl_u.stop_cond();
    chk_flag("prog_busy", 1'b1, prog_busy);
    wait_busy(1'b0, PROG_N + 100);
    chk_flag("prog time", 1'b1, (cyc - t0) <= PROG_N + 40);
    chk_word("count", 18'h1, 18'(got_q.size()));
    chk_word("word", {10'h137, 8'h5c}, got_q[0]);
    chk_flag("standby", 1'b1, standby);
    ctl_u.start_cond();
    send(8'haa, 1'b1);
    ctl_u.stop_cond();
    $display("test byte done");
  endtask : test_byte

  task automatic test_page();
    int i;
    chip_select_hi = 1'b0;
    chip_select_lo = 1'b0;
    got_q.delete();
    prog_ready = 1'b0;
    ctl_u.start_cond();
    send(8'ha0, 1'b1);
    send(8'h2e, 1'b1);
    for (int k = 0; k < 18; k++)
      send(8'h40 + 8'(k), 1'b1);
    ctl_u.stop_cond();
    wait_busy(1'b1, 20);
    ctl_u.wt(30);
    chk_word("held", {10'h020, 8'h42}, {prog_addr, prog_data});
    ctl_u.wt(30);
    chk_word("held", {10'h020, 8'h42}, {prog_addr, prog_data});
    chk_flag("prog_valid", 1'b1, prog_valid);
    // alternate back-pressure while the page drains
    repeat (8)
    begin
      prog_ready = ~prog_ready;
      ctl_u.wt(1);
    end
    prog_ready = 1'b1;
    wait_busy(1'b0, PROG_N + 100);
    chk_word("count", 18'h10, 18'(got_q.size()));
    for (int o = 0; o < 16; o++)
    begin
      i = (o + 2) % 16;
      if (i < 2)
        i += 16;
      chk_word("page word", {10'h020 + 10'(o), 8'h40 + 8'(i)}, got_q[o]);
    end
    $display("test page done");
  endtask : test_page

  task automatic test_recover();
    logic s;
    ctl_u.start_cond();
    for (int k = 3; k >= 0; k--)
      ctl_u.bit_cyc(k[0], s);
    ctl_u.recover();
    ctl_u.start_cond();
    send(8'ha1, 1'b1);
    ctl_u.stop_cond();
    chk_flag("standby", 1'b1, standby);
    chk_flag("sda_oe_n", 1'b1, sda_oe_n);
    $display("test recover done");
  endtask : test_recover

  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    rst = 1'b1;
    chip_select_hi = 1'b0;
    chip_select_lo = 1'b0;
    prog_ready = 1'b1;
    test_reset();
    test_strap();
    test_byte();
    test_page();
    test_recover();
    tally_and_finish();
  end
endmodule : tb

`default_nettype wire
